// ===== rtc_pkg.sv
// constants, types and reset values for the wrap-limit / match registers
// assumes a single 100 MHz clock and an AHB-Lite master with word access
//
// How it works
// [RULE_01] wrap limit low byte sits at index 0x0a, high byte at 0x0b.
// [RULE_02] high byte location holds bits 15:8, low byte holds bits 7:0.
// [RULE_03] a new wrap limit takes effect two counter ticks after the write.
// [RULE_04] software waits for wrap sync pending clear before writing again.
// [RULE_05] match value low byte sits at index 0x0c, high byte at 0x0d.
// [RULE_06] count equal wrap limit sets wrap flag and returns count to zero.
// [RULE_07] count equal match value sets match flag; write one clears it.
// [RULE_08] read-only pending bits show wrap and match values still syncing.
// [RULE_09] one shared 8-bit staging byte makes each 16-bit access atomic.
// [RULE_10] pending bit holds from write until value is live, then clears.
package rtc_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ = 100_000_000;
  localparam int unsigned CNT_CLK_HZ = 32_768;
  localparam int unsigned TICK_DIV   = SYS_CLK_HZ / CNT_CLK_HZ;
  localparam logic [1:0]  SYNC_LAST  = 2'h1;  // ticks 0 and 1: two ticks

  // ---------------------------------------------------------------
  // register indices; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_STATUS = 6'h01;
  localparam logic [5:0] IDX_MASK   = 6'h02;
  localparam logic [5:0] IDX_FLAGS  = 6'h03;
  localparam logic [5:0] IDX_TEMP   = 6'h04;
  localparam logic [5:0] IDX_CNTL   = 6'h08;
  localparam logic [5:0] IDX_CNTH   = 6'h09;
  localparam logic [5:0] IDX_WRAPL  = 6'h0a;
  localparam logic [5:0] IDX_WRAPH  = 6'h0b;
  localparam logic [5:0] IDX_MATCHL = 6'h0c;
  localparam logic [5:0] IDX_MATCHH = 6'h0d;

  // field positions
  localparam int unsigned FLAG_WRAP     = 0;
  localparam int unsigned FLAG_MATCH    = 1;
  localparam int unsigned ST_WRAP_PEND  = 2;
  localparam int unsigned ST_MATCH_PEND = 3;

  // reset values
  localparam logic [15:0] WRAP_RST  = 16'h00ff;
  localparam logic [15:0] MATCH_RST = 16'h0000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ  = 2'b10
  } bus_phase_e;

  typedef struct packed {
    logic        hsel;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [7:0]  haddr;
    logic [31:0] hwdata;
  } ahb_req_s;

  typedef struct packed {
    bus_phase_e  phase;
    logic [5:0]  idx;
    logic        hreadyout;
    logic [31:0] rdata;
    logic        irq;
    logic [7:0]  temp;
    logic [15:0] wrap_shadow;
    logic [15:0] wrap_act;
    logic [1:0]  wrap_sync;
    logic        wrap_pend;
    logic [15:0] match_shadow;
    logic [15:0] match_act;
    logic [1:0]  match_sync;
    logic        match_pend;
    logic [15:0] count;
    logic [1:0]  flags;
    logic [1:0]  mask;
  } regs_s;

  localparam regs_s REGS_RST = '{
    phase: PH_IDLE, idx: 6'h00, hreadyout: 1'b1, rdata: 32'h0000_0000,
    irq: 1'b0, temp: 8'h00,
    wrap_shadow: WRAP_RST, wrap_act: WRAP_RST, wrap_sync: 2'h0,
    wrap_pend: 1'b0,
    match_shadow: MATCH_RST, match_act: MATCH_RST, match_sync: 2'h0,
    match_pend: 1'b0,
    count: 16'h0000, flags: 2'h0, mask: 2'h0
  };

endpackage

// ===== rtc_tick_div.sv
// divider making the one-cycle counter tick enable
// assumes the system clock; the tick stands for one counter-clock edge
module rtc_tick_div #(
  parameter int unsigned DIV = rtc_pkg::TICK_DIV
) (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_arst_n,
  // tick
  output logic      o_tick
);

  localparam int unsigned CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } div_s;

  div_s q;
  div_s d;

  always_comb begin
    d      = q;
    d.tick = (q.cnt == LAST);
    d.cnt  = d.tick ? '0 : q.cnt + CW'(1);
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_tick = q.tick;

endmodule

// ===== rtc_period_compare_regs.sv
// wrap-limit and match registers of the real-time counter, AHB-Lite slave
// assumes a single-slave bus: i_hready is this slave's own o_hreadyout
//
// The implementer's own choice: the AHB-Lite interface to the registers.
module rtc_period_compare_regs #(
  parameter int unsigned TICK_DIV = rtc_pkg::TICK_DIV
) (
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_arst_n,
  // ahb-lite request
  input  wire rtc_pkg::ahb_req_s i_ahb,
  input  wire logic              i_hready,
  // ahb-lite response
  output logic                   o_hreadyout,
  output logic [31:0]            o_hrdata,
  output logic                   o_hresp,
  // interrupt
  output logic                   o_irq
);

  rtc_pkg::regs_s q;
  rtc_pkg::regs_s d;
  logic           tick;
  logic           resp_q;

  // ---------------------------------------------------------------
  // counter-clock tick
  // ---------------------------------------------------------------
  rtc_tick_div #(
    .DIV (TICK_DIV)
  ) u_tick (
    .i_ref_clk (i_ref_clk),
    .i_arst_n  (i_arst_n),
    .o_tick    (tick)
  );

  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h00_0000, b};
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic [1:0] ev;
  logic [1:0] clr;

  always_comb begin
    d   = q;
    ev  = 2'h0;
    clr = 2'h0;

    // counting side, advanced only on the tick
    if (tick) begin
      if (q.count == q.wrap_act) begin
        d.count         = 16'h0000; // RULE_06
        ev[rtc_pkg::FLAG_WRAP] = 1'b1; // RULE_06
      end else begin
        d.count = q.count + 16'h0001;
      end
      ev[rtc_pkg::FLAG_MATCH] = (q.count == q.match_act); // RULE_07
    end

    // carry shadow values into the counting side after two ticks
    if (q.wrap_pend && tick) begin
      if (q.wrap_sync == rtc_pkg::SYNC_LAST) begin
        d.wrap_act  = q.wrap_shadow; // RULE_03
        d.wrap_pend = 1'b0; // RULE_10
        d.wrap_sync = 2'h0;
      end else begin
        d.wrap_sync = q.wrap_sync + 2'h1;
      end
    end
    if (q.match_pend && tick) begin
      if (q.match_sync == rtc_pkg::SYNC_LAST) begin
        d.match_act  = q.match_shadow;
        d.match_pend = 1'b0; // RULE_10
        d.match_sync = 2'h0;
      end else begin
        d.match_sync = q.match_sync + 2'h1;
      end
    end

    // data phase of the previous transfer
    d.hreadyout = 1'b1;
    case (q.phase)
      rtc_pkg::PH_WRITE: begin
        if (q.idx == rtc_pkg::IDX_WRAPL) begin
          d.temp = i_ahb.hwdata[7:0]; // RULE_09
        end else if (q.idx == rtc_pkg::IDX_WRAPH) begin
          // a write during pending restarts the sync; software must wait
          d.wrap_shadow = {i_ahb.hwdata[7:0], q.temp}; // RULE_02
          d.wrap_pend   = 1'b1; // RULE_08
          d.wrap_sync   = 2'h0;
        end else if (q.idx == rtc_pkg::IDX_MATCHL) begin
          d.temp = i_ahb.hwdata[7:0]; // RULE_09
        end else if (q.idx == rtc_pkg::IDX_MATCHH) begin
          d.match_shadow = {i_ahb.hwdata[7:0], q.temp}; // RULE_05
          d.match_pend   = 1'b1; // RULE_08
          d.match_sync   = 2'h0;
        end else if (q.idx == rtc_pkg::IDX_TEMP) begin
          d.temp = i_ahb.hwdata[7:0];
        end else if (q.idx == rtc_pkg::IDX_MASK) begin
          d.mask = i_ahb.hwdata[1:0];
        end else if (q.idx == rtc_pkg::IDX_FLAGS) begin
          clr = i_ahb.hwdata[1:0];
        end
      end
      rtc_pkg::PH_READ: begin
        d.rdata = 32'h0000_0000;
        if (q.idx == rtc_pkg::IDX_WRAPL) begin
          d.rdata = byte_word(q.wrap_shadow[7:0]); // RULE_01
          d.temp  = q.wrap_shadow[15:8]; // RULE_09
        end else if (q.idx == rtc_pkg::IDX_WRAPH) begin
          d.rdata = byte_word(q.temp); // RULE_02
        end else if (q.idx == rtc_pkg::IDX_MATCHL) begin
          d.rdata = byte_word(q.match_shadow[7:0]); // RULE_05
          d.temp  = q.match_shadow[15:8]; // RULE_09
        end else if (q.idx == rtc_pkg::IDX_MATCHH) begin
          d.rdata = byte_word(q.temp);
        end else if (q.idx == rtc_pkg::IDX_CNTL) begin
          d.rdata = byte_word(q.count[7:0]);
          d.temp  = q.count[15:8];
        end else if (q.idx == rtc_pkg::IDX_CNTH) begin
          d.rdata = byte_word(q.temp);
        end else if (q.idx == rtc_pkg::IDX_TEMP) begin
          d.rdata = byte_word(q.temp);
        end else if (q.idx == rtc_pkg::IDX_STATUS) begin
          d.rdata[rtc_pkg::ST_WRAP_PEND]  = q.wrap_pend; // RULE_08
          d.rdata[rtc_pkg::ST_MATCH_PEND] = q.match_pend; // RULE_08
        end else if (q.idx == rtc_pkg::IDX_MASK) begin
          d.rdata = {30'h0000_0000, q.mask};
        end else if (q.idx == rtc_pkg::IDX_FLAGS) begin
          d.rdata = {30'h0000_0000, q.flags};
        end
      end
      default: begin
      end
    endcase

    // address phase; reads take one wait state because the read data is
    // registered and reaches o_hrdata one cycle after it is picked
    d.phase = rtc_pkg::PH_IDLE;
    if (i_ahb.hsel && i_ahb.htrans[1] && i_hready) begin
      d.idx = i_ahb.haddr[7:2];
      if (i_ahb.hwrite) begin
        d.phase = rtc_pkg::PH_WRITE;
      end else begin
        d.phase     = rtc_pkg::PH_READ;
        d.hreadyout = 1'b0;
      end
    end

    // a new event wins over a clear in the same cycle
    d.flags = (q.flags & ~clr) | ev; // RULE_06 RULE_07
    d.irq   = |(q.flags & q.mask);
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q      <= rtc_pkg::REGS_RST;
      resp_q <= 1'b0;
    end else begin
      q      <= d;
      resp_q <= 1'b0;
    end
  end

  assign o_hreadyout = q.hreadyout;
  assign o_hrdata    = q.rdata;
  assign o_hresp     = resp_q;
  assign o_irq       = q.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [1:0] wrap_ticks_h;

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wrap_ticks_h <= 2'h0;
    end else if (q.phase == rtc_pkg::PH_WRITE &&
                 q.idx == rtc_pkg::IDX_WRAPH) begin
      wrap_ticks_h <= 2'h0;
    end else if (q.wrap_pend && tick) begin
      wrap_ticks_h <= wrap_ticks_h + 2'h1;
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);

  sequence s_rd(logic [5:0] idx);
    q.phase == rtc_pkg::PH_READ && q.idx == idx;
  endsequence

  sequence s_wr(logic [5:0] idx);
    q.phase == rtc_pkg::PH_WRITE && q.idx == idx;
  endsequence

  wrap_low_read_a: assert property ( // RULE_01
    s_rd(rtc_pkg::IDX_WRAPL) |=>
      o_hrdata == {24'h00_0000, $past(q.wrap_shadow[7:0])} && o_hreadyout)
    else $error("wrap low byte read wrong");

  wrap_high_pair_a: assert property ( // RULE_02
    s_rd(rtc_pkg::IDX_WRAPL) |=> q.temp == $past(q.wrap_shadow[15:8]))
    else $error("wrap high byte not staged by low read");

  wrap_sync_two_a: assert property ( // RULE_03
    $fell(q.wrap_pend) |-> wrap_ticks_h == 2'h2 &&
      q.wrap_act == q.wrap_shadow)
    else $error("wrap limit not live after two ticks");

  match_commit_a: assert property ( // RULE_05
    s_wr(rtc_pkg::IDX_MATCHH) |=>
      q.match_shadow == {$past(i_ahb.hwdata[7:0]), $past(q.temp)})
    else $error("match value commit wrong");

  wrap_event_a: assert property ( // RULE_06
    tick && q.count == q.wrap_act |=> q.flags[0] && q.count == 16'h0000)
    else $error("wrap event missing");

  match_event_a: assert property ( // RULE_07
    tick && q.count == q.match_act |=> q.flags[1])
    else $error("match event missing");

  pend_set_a: assert property ( // RULE_08
    s_wr(rtc_pkg::IDX_WRAPH) |=> q.wrap_pend && q.wrap_sync == 2'h0)
    else $error("wrap pending not raised on commit");

  low_write_stage_a: assert property ( // RULE_09
    s_wr(rtc_pkg::IDX_WRAPL) |=> $stable(q.wrap_shadow) &&
      q.temp == $past(i_ahb.hwdata[7:0]))
    else $error("low byte write touched the value");

  pend_hold_a: assert property ( // RULE_10
    q.wrap_pend && !tick |=> q.wrap_pend)
    else $error("wrap pending dropped without tick");

  irq_level_a: assert property (
    1'b1 |=> o_irq == $past(|(q.flags & q.mask)))
    else $error("interrupt level wrong");

endmodule

// ===== testbench.sv
// self-checking bench for the wrap-limit / match registers
// assumes one 100 MHz clock and the slave alone on an AHB-Lite bus
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int unsigned DIV = 4;  // short tick keeps waits in cycles
  logic              ref_clk;
  logic              arst_n;
  rtc_pkg::ahb_req_s ahb;
  logic              hreadyout;
  logic [31:0]       hrdata;
  logic              hresp;
  logic              irq;
  logic [31:0]       rd;
  int                err_count;
  int                n_checks;
  int                cyc;

  typedef struct {
    logic [5:0]  idx;
    logic [31:0] exp;
  } row_s;
  row_s rows [9];

  rtc_period_compare_regs #(
    .TICK_DIV    (DIV)
  ) u_rtc_period_compare_regs (
    .i_ref_clk   (ref_clk),
    .i_arst_n    (arst_n),
    .i_ahb       (ahb),
    .i_hready    (hreadyout),
    .o_hreadyout (hreadyout),
    .o_hrdata    (hrdata),
    .o_hresp     (hresp),
    .o_irq       (irq)
  );

  // ---------------------------------------------------------------
  // clock, timeout and report
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // whole run needs well under 5000 cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ---------------------------------------------------------------
  // bus master
  // ---------------------------------------------------------------
  // called right after a rising edge; hready is judged at rising edges,
  // where the registered value seen is the one the slave launched before
  task automatic bus(input logic wr, input logic [5:0] idx,
                     input logic [7:0] wd, output logic [31:0] q);
    ahb.hsel   <= 1'b1;
    ahb.htrans <= 2'b10;
    ahb.hwrite <= wr;
    ahb.haddr  <= {idx, 2'b00};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    ahb.htrans <= 2'b00;
    ahb.hwdata <= {24'h00_0000, wd};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr8(logic [5:0] idx, logic [7:0] wd);
    logic [31:0] q;
    bus(1'b1, idx, wd, q);
  endtask

  task automatic rd_chk(string what, logic [5:0] idx, logic [31:0] exp);
    bus(1'b0, idx, 8'h00, rd);
    check(what, exp, rd);
  endtask

  // no write of a 16-bit value until both pending bits read clear
  task automatic wait_sync();
    int n;
    n = 0;
    bus(1'b0, rtc_pkg::IDX_STATUS, 8'h00, rd);
    while (rd[3:2] !== 2'b00 && n < 20) begin
      bus(1'b0, rtc_pkg::IDX_STATUS, 8'h00, rd);
      n++;
    end
    check("pending clears", 32'h0, {28'h0, rd[3:2], 2'b00});
  endtask

  task automatic put16(logic [5:0] idx, logic [15:0] v);
    wr8(idx, v[7:0]);
    wr8(idx + 6'h01, v[15:8]);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    ahb = '0;
    ahb.hsize = 3'h2;
    err_count = 0;
    n_checks = 0;
    cyc = 0;
    rows = '{
      '{rtc_pkg::IDX_STATUS, 32'h0}, '{rtc_pkg::IDX_MASK, 32'h0},
      '{rtc_pkg::IDX_FLAGS, 32'h2},  '{rtc_pkg::IDX_TEMP, 32'h0},
      '{rtc_pkg::IDX_WRAPL, 32'hff}, '{rtc_pkg::IDX_WRAPH, 32'h0},
      '{rtc_pkg::IDX_MATCHL, 32'h0}, '{rtc_pkg::IDX_MATCHH, 32'h0},
      '{6'h3f, 32'h0}
    };
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    check("hreadyout after reset", 32'h1, {31'h0, hreadyout});
    check("hresp", 32'h0, {31'h0, hresp});
    check("irq after reset", 32'h0, {31'h0, irq});
    // reset values, unmapped index last; count 0 meets match 0 at once
    foreach (rows[i]) begin
      rd_chk("reset read", rows[i].idx, rows[i].exp);
    end
    $display("test reset values done");

    // byte placement and pending bit
    put16(rtc_pkg::IDX_WRAPL, 16'h1234);
    rd_chk("wrap pending", rtc_pkg::IDX_STATUS, 32'h4);
    wait_sync();
    rd_chk("wrap low", rtc_pkg::IDX_WRAPL, 32'h34);
    rd_chk("wrap high", rtc_pkg::IDX_WRAPH, 32'h12);
    put16(rtc_pkg::IDX_MATCHL, 16'hab56);
    rd_chk("match pending", rtc_pkg::IDX_STATUS, 32'h8);
    wait_sync();
    rd_chk("match low", rtc_pkg::IDX_MATCHL, 32'h56);
    rd_chk("match high", rtc_pkg::IDX_MATCHH, 32'hab);
    $display("test byte placement done");

    // staging byte shared: wrap low byte ends up in match
    wr8(rtc_pkg::IDX_WRAPL, 8'h05);
    wr8(rtc_pkg::IDX_MATCHH, 8'h00);
    wait_sync();
    rd_chk("shared temp", rtc_pkg::IDX_MATCHL, 32'h05);
    rd_chk("wrap kept", rtc_pkg::IDX_WRAPL, 32'h34);
    $display("test shared staging done");

    // reset in mid-run: count restarts, so short limits are reachable
    arst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    check("irq after second reset", 32'h0, {31'h0, irq});
    rd_chk("wrap after second reset", rtc_pkg::IDX_WRAPL, 32'hff);
    $display("test mid-run reset done");

    // short wrap limit: both flags raise, masks gate irq
    put16(rtc_pkg::IDX_WRAPL, 16'h0003);
    wait_sync();
    put16(rtc_pkg::IDX_MATCHL, 16'h0002);
    wait_sync();
    // new limit goes live before count passes 3, so count wraps at 3 within the wait
    repeat (1100) @(posedge ref_clk);
    rd_chk("flags set", rtc_pkg::IDX_FLAGS, 32'h3);
    for (int m = 0; m < 4; m++) begin
      wr8(rtc_pkg::IDX_MASK, m[7:0]);
      repeat (2) @(posedge ref_clk);
      check("irq mask", {31'h0, m != 0}, {31'h0, irq});
    end
    $display("test flags and irq done");

    // long limits: flags stay clear after write-one
    put16(rtc_pkg::IDX_WRAPL, 16'hffff);
    wait_sync();
    put16(rtc_pkg::IDX_MATCHL, 16'hfff0);
    wait_sync();
    wr8(rtc_pkg::IDX_FLAGS, 8'h03);
    rd_chk("flags cleared", rtc_pkg::IDX_FLAGS, 32'h0);
    repeat (2) @(posedge ref_clk);
    check("irq cleared", 32'h0, {31'h0, irq});
    bus(1'b0, rtc_pkg::IDX_CNTL, 8'h00, rd);
    rd_chk("count high", rtc_pkg::IDX_CNTH, 32'h0);
    $display("test flag clear done");
    end_of_test();
  end
endmodule
